// File: rtl/mise_decimal_adjust.sv
/*
  Combinational decimal adjust of one byte after a binary addition.
  Assumes carry and half-carry reflect the addition that produced the byte.
*/
`timescale 1ns/1ps
module mise_decimal_adjust
  import mise_pkg::*;
(
  // operand and flags
  input wire logic [7:0] value_in,
  input wire logic carry_in,
  input wire logic half_carry_in,
  // result
  output logic [7:0] result_out,
  output logic carry_out
);

  logic [8:0] low_fixed;
  logic high_fix;

  // low nibble correction, carry into bit 8 kept
  always_comb
  begin
    if ((value_in[3:0] > DA_NIBBLE_LIMIT) || half_carry_in)
      low_fixed = {1'b0, value_in} + {1'b0, DA_LOW_ADJUST};
    else
      low_fixed = {1'b0, value_in};
  end

  // high nibble correction and final carry
  assign high_fix = (low_fixed[7:4] > DA_NIBBLE_LIMIT) || carry_in || low_fixed[8];
  assign result_out = high_fix ? (low_fixed[7:0] + DA_HIGH_ADJUST) : low_fixed[7:0];
  assign carry_out = high_fix;

endmodule : mise_decimal_adjust

// File: rtl/mise_exec.sv
/*
  Execute stage for decimal adjust, decrement-skip-if-zero, global interrupt
  disable/allow and absolute jump. One sys_clk edge is one instruction cycle.
  Assumes the register file answers file_rdata_in combinationally for
  file_raddr_out, and that the status register owner applies carry writes.
*/
`timescale 1ns/1ps
module mise_exec
  import mise_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // decoded instruction
  input wire logic op_valid_in,
  input wire mise_op_t op_code_in,
  input wire logic [FILE_ADDR_W-1:0] file_addr_in,
  input wire logic dest_bit_in,
  input wire logic [JUMP_W-1:0] jump_target_in,
  output logic op_ready_out,
  output logic discard_out,
  // core state inputs
  input wire logic [DATA_W-1:0] working_register_in,
  input wire logic carry_in,
  input wire logic half_carry_in,
  input wire logic [DATA_W-1:0] pc_high_buffer_in,
  // working register and carry write
  output logic working_register_wr_out,
  output logic [DATA_W-1:0] working_register_out,
  output logic carry_wr_out,
  output logic carry_out,
  // register file
  output logic [FILE_ADDR_W-1:0] file_raddr_out,
  input wire logic [DATA_W-1:0] file_rdata_in,
  output logic file_wr_out,
  output logic [FILE_ADDR_W-1:0] file_waddr_out,
  output logic [DATA_W-1:0] file_wdata_out,
  // program counter and interrupt enable
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_target_out,
  output logic global_irq_enable_bit_out
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_op(input logic take, input mise_op_t code, input mise_op_t want);
    is_op = take && (code == want);
  endfunction : is_op

  mise_state_t state_reg;
  logic take;
  logic do_da;
  logic do_dec;
  logic do_dis;
  logic do_allow;
  logic do_jump;
  logic [DATA_W-1:0] dec_result;
  logic dec_zero;
  logic [DATA_W-1:0] da_result;
  logic da_carry;

  // request accepted only in an execute cycle
  assign op_ready_out = (state_reg == ST_EXEC);
  assign discard_out = (state_reg == ST_DISCARD);
  assign take = op_valid_in && op_ready_out;
  assign do_da = is_op(take, op_code_in, decimal_adjust_op);
  assign do_dec = is_op(take, op_code_in, decrement_skip_zero_op);
  assign do_dis = is_op(take, op_code_in, global_irq_disable_op);
  assign do_allow = is_op(take, op_code_in, global_irq_allow_op);
  assign do_jump = is_op(take, op_code_in, absolute_jump_op);

  // decrement datapath
  assign file_raddr_out = file_addr_in;
  assign dec_result = file_rdata_in - DEC_ONE;
  assign dec_zero = (dec_result == '0);

  // decimal adjust unit
  mise_decimal_adjust u_da (
    .value_in(working_register_in),
    .carry_in(carry_in),
    .half_carry_in(half_carry_in),
    .result_out(da_result),
    .carry_out(da_carry)
  );

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  // second cycle of a skip or jump swallows the fetched word
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      state_reg <= ST_EXEC;
    else
    begin
      unique case (state_reg)
        ST_EXEC:
        begin
          if ((do_dec && dec_zero) || do_jump)
            state_reg <= ST_DISCARD;
        end
        ST_DISCARD:
          state_reg <= ST_EXEC;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result writes
  // ----------------------------------------------------------------
  // working register write from decimal adjust or decrement
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      working_register_wr_out <= 1'b0;
      working_register_out <= '0;
    end
    else
    begin
      working_register_wr_out <= do_da || (do_dec && !dest_bit_in);
      if (do_da)
        working_register_out <= da_result;
      else if (do_dec && !dest_bit_in)
        working_register_out <= dec_result;
    end
  end

  // carry is the only flag touched, and only by decimal adjust
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      carry_wr_out <= 1'b0;
      carry_out <= 1'b0;
    end
    else
    begin
      carry_wr_out <= do_da;
      if (do_da)
        carry_out <= da_carry;
    end
  end

  // file register write-back
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      file_wr_out <= 1'b0;
      file_waddr_out <= '0;
      file_wdata_out <= '0;
    end
    else
    begin
      file_wr_out <= do_dec && dest_bit_in;
      if (do_dec && dest_bit_in)
      begin
        file_waddr_out <= file_addr_in;
        file_wdata_out <= dec_result;
      end
    end
  end

  // jump target load
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      pc_load_out <= 1'b0;
      pc_target_out <= '0;
    end
    else
    begin
      pc_load_out <= do_jump;
      if (do_jump)
        pc_target_out <= {pc_high_buffer_in[PCHB_JUMP_BIT], jump_target_in};
    end
  end

  // global interrupt enable bit
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      global_irq_enable_bit_out <= RST_IRQ_ENABLE;
    else if (do_dis)
      global_irq_enable_bit_out <= 1'b0;
    else if (do_allow)
      global_irq_enable_bit_out <= 1'b1;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DA_WRITE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_da |=> working_register_wr_out && (working_register_out == $past(da_result)))
    else $error("decimal adjust result not written");

  AST_DA_CARRY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_da |=> carry_wr_out && (carry_out == $past(da_carry)) && !file_wr_out && op_ready_out)
    else $error("decimal adjust carry wrong");

  AST_DA_IDLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (do_da && !carry_in && !half_carry_in && (working_register_in <= DA_BYTE_LIMIT)
      && (working_register_in[3:0] <= DA_NIBBLE_LIMIT))
    |=> (working_register_out == $past(working_register_in)) && !carry_out)
    else $error("decimal adjust changed a valid decimal byte");

  AST_DEC_TO_WREG: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (do_dec && !dest_bit_in) |=> working_register_wr_out && !file_wr_out
      && (working_register_out == $past(file_rdata_in) - DEC_ONE))
    else $error("decrement to working register wrong");

  AST_DEC_TO_FILE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (do_dec && dest_bit_in) |=> file_wr_out && !working_register_wr_out
      && (file_waddr_out == $past(file_addr_in))
      && (file_wdata_out == $past(file_rdata_in) - DEC_ONE))
    else $error("decrement to file register wrong");

  AST_DEC_SKIP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (do_dec && (file_rdata_in == DEC_ONE)) |=> discard_out && !op_ready_out ##1 op_ready_out)
    else $error("zero result did not discard one instruction");

  AST_DEC_NOSKIP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (do_dec && (file_rdata_in != DEC_ONE)) |=> op_ready_out && !discard_out)
    else $error("nonzero decrement stalled");

  AST_IRQ_OFF: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_dis |=> !global_irq_enable_bit_out && !carry_wr_out && op_ready_out)
    else $error("interrupt disable failed");

  AST_IRQ_ON: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_allow |=> global_irq_enable_bit_out && !carry_wr_out && op_ready_out)
    else $error("interrupt allow failed");

  AST_DISCARD_NOP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    discard_out |=> !working_register_wr_out && !carry_wr_out && !file_wr_out && !pc_load_out)
    else $error("discarded word had an effect");

  AST_JUMP_TARGET: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_jump |=> pc_load_out && !carry_wr_out
      && (pc_target_out == {$past(pc_high_buffer_in[PCHB_JUMP_BIT]), $past(jump_target_in)}))
    else $error("jump target wrong");

  AST_JUMP_TWO: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    do_jump |=> discard_out ##1 (op_ready_out && !pc_load_out))
    else $error("jump not two cycles");

endmodule : mise_exec

// File: rtl/mise_pkg.sv
/*
  Shared constants and types for the five-instruction execution slice of the core.
  Assumes it is compiled before every module that imports it.
*/
package mise_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 6;
  localparam int JUMP_W = 9;
  localparam int PC_W = 10;
  localparam int PCHB_JUMP_BIT = 1;

  // ----------------------------------------------------------------
  // decimal adjust constants
  // ----------------------------------------------------------------
  localparam logic [3:0] DA_NIBBLE_LIMIT = 4'h9;
  localparam logic [7:0] DA_LOW_ADJUST = 8'h06;
  localparam logic [7:0] DA_HIGH_ADJUST = 8'h60;
  localparam logic [7:0] DA_BYTE_LIMIT = 8'h99;

  // ----------------------------------------------------------------
  // reset value and decrement step
  // ----------------------------------------------------------------
  localparam logic RST_IRQ_ENABLE = 1'b0;
  localparam logic [7:0] DEC_ONE = 8'h01;

  // ----------------------------------------------------------------
  // operations and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    decimal_adjust_op,
    decrement_skip_zero_op,
    global_irq_disable_op,
    global_irq_allow_op,
    absolute_jump_op
  } mise_op_t;

  typedef enum logic {
    ST_EXEC,
    ST_DISCARD
  } mise_state_t;

endpackage : mise_pkg

// File: testbench/tb.sv
/*
  Self-checking bench for the execute slice: decimal adjust table, decrement-skip,
  interrupt enable control, absolute jump, refused discard cycle and mid-run reset.
  Assumes the package is compiled first and that the assertions live in the design files.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb
  import mise_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic half_carry;
    logic [7:0] result;
    logic carry_res;
  } mise_da_row_t;
  logic sys_clk, reset, op_valid, dest_bit, carry, half_carry;
  mise_op_t op_code;
  logic [5:0] file_addr;
  logic [8:0] jump_target;
  logic [7:0] wreg, pchb, rdata;
  logic ready, discard, wreg_wr, carry_wr, carry_res, file_wr, pc_load, irq_en;
  logic [7:0] wreg_res, file_wdata;
  logic [5:0] file_raddr, file_waddr;
  logic [9:0] pc_target;
  int error_cnt = 0;
  int total_checks = 0;
  mise_da_row_t rows [8] = '{'{8'h4D, 1'b0, 1'b0, 8'h53, 1'b0}, '{8'h12, 1'b0, 1'b1, 8'h18, 1'b0},
    '{8'hA0, 1'b0, 1'b0, 8'h00, 1'b1}, '{8'h15, 1'b1, 1'b0, 8'h75, 1'b1},
    '{8'h99, 1'b0, 1'b0, 8'h99, 1'b0}, '{8'h9A, 1'b0, 1'b0, 8'h00, 1'b1},
    '{8'h0F, 1'b0, 1'b0, 8'h15, 1'b0}, '{8'hFA, 1'b0, 1'b0, 8'h60, 1'b1}};

  // device under test
  mise_exec mise_exec_i (.sys_clk_in(sys_clk), .reset_in(reset), .op_valid_in(op_valid),
    .op_code_in(op_code), .file_addr_in(file_addr), .dest_bit_in(dest_bit),
    .jump_target_in(jump_target), .op_ready_out(ready), .discard_out(discard),
    .working_register_in(wreg), .carry_in(carry), .half_carry_in(half_carry),
    .pc_high_buffer_in(pchb), .working_register_wr_out(wreg_wr),
    .working_register_out(wreg_res), .carry_wr_out(carry_wr), .carry_out(carry_res),
    .file_raddr_out(file_raddr), .file_rdata_in(rdata), .file_wr_out(file_wr),
    .file_waddr_out(file_waddr), .file_wdata_out(file_wdata), .pc_load_out(pc_load),
    .pc_target_out(pc_target), .global_irq_enable_bit_out(irq_en));

  // ----------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // prints the verdict and stops the run
  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // holds a request over one taking edge, returns in the answer cycle
  task automatic exec(input mise_op_t op, input logic [5:0] addr, input logic dest);
    op_code = op;
    file_addr = addr;
    dest_bit = dest;
    op_valid = 1'b1;
    @(posedge sys_clk);
    #2;
  endtask : exec

  // drops the request and lets one edge pass
  task automatic idle();
    op_valid = 1'b0;
    @(posedge sys_clk);
    #2;
  endtask : idle

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    #(25 * 2000);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    {reset, op_valid, dest_bit, carry, half_carry, file_addr, jump_target} = '0;
    op_code = decimal_adjust_op;
    {wreg, pchb, rdata} = '0;
    reset = 1'b1;
    repeat (12) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    `CHK(irq_en, 1'b0)
    `CHK(ready, 1'b1)
    // decimal adjust table, back to back
    foreach (rows[i])
    begin
      {wreg, carry, half_carry} = {rows[i].value, rows[i].carry, rows[i].half_carry};
      exec(decimal_adjust_op, 6'h00, 1'b0);
      `CHK({wreg_wr, wreg_res}, {1'b1, rows[i].result})
      `CHK({carry_wr, carry_res, file_wr}, {1'b1, rows[i].carry_res, 1'b0})
    end
    // decrement to working register, no skip, then wrap from zero into a file register
    rdata = 8'h05;
    exec(decrement_skip_zero_op, 6'h3F, 1'b0);
    `CHK(file_raddr, 6'h3F)
    `CHK({wreg_wr, wreg_res, file_wr, carry_wr}, {1'b1, 8'h04, 1'b0, 1'b0})
    `CHK({discard, ready}, 2'b01)
    rdata = 8'h00;
    exec(decrement_skip_zero_op, 6'h00, 1'b1);
    `CHK({file_wr, file_waddr, file_wdata, wreg_wr}, {1'b1, 6'h00, 8'hFF, 1'b0})
    `CHK({discard, ready}, 2'b01)
    // decrement to zero: skip, the fetched word is refused
    rdata = 8'h01;
    exec(decrement_skip_zero_op, 6'h3F, 1'b1);
    `CHK({file_wr, file_waddr, file_wdata}, {1'b1, 6'h3F, 8'h00})
    `CHK({discard, ready}, 2'b10)
    {wreg, carry} = {8'h4D, 1'b1};
    exec(decimal_adjust_op, 6'h00, 1'b0);
    `CHK({wreg_wr, carry_wr, file_wr}, 3'b000)
    `CHK({discard, ready}, 2'b01)
    // decrement to zero into working register also skips
    exec(decrement_skip_zero_op, 6'h01, 1'b0);
    `CHK({wreg_wr, wreg_res, discard}, {1'b1, 8'h00, 1'b1})
    idle();
    // interrupt allow then disable, back to back
    exec(global_irq_allow_op, 6'h00, 1'b0);
    `CHK(irq_en, 1'b1)
    exec(global_irq_disable_op, 6'h00, 1'b0);
    `CHK({irq_en, carry_wr, wreg_wr, discard}, 4'b0000)
    // absolute jump with page bit set and clear
    {jump_target, pchb} = {9'h1A5, 8'h02};
    exec(absolute_jump_op, 6'h00, 1'b0);
    `CHK({pc_load, pc_target}, {1'b1, 10'h3A5})
    `CHK({discard, ready, carry_wr}, 3'b100)
    exec(absolute_jump_op, 6'h00, 1'b0);
    `CHK(pc_load, 1'b0)
    {jump_target, pchb} = {9'h0FF, 8'hFD};
    exec(absolute_jump_op, 6'h00, 1'b0);
    `CHK({pc_load, pc_target, discard}, {1'b1, 10'h0FF, 1'b1})
    idle();
    `CHK({pc_load, ready}, 2'b01)
    // reset in mid-run, inside a jump's discard cycle, clears the enable bit and sequencer
    exec(global_irq_allow_op, 6'h00, 1'b0);
    exec(absolute_jump_op, 6'h00, 1'b0);
    `CHK({irq_en, discard}, 2'b11)
    op_valid = 1'b0;
    reset = 1'b1;
    @(posedge sys_clk);
    #2;
    reset = 1'b0;
    `CHK({irq_en, ready, discard, pc_load}, 4'b0100)
    // first edge after release already takes a request
    exec(global_irq_allow_op, 6'h00, 1'b0);
    `CHK(irq_en, 1'b1)
    wrap_up();
  end
endmodule : tb
